// file: abx_pkg.sv
// abx_pkg: encodings, field positions and carrier types for the add/and/beq execute slice
// assumes: shared by the execute top and its register-file module
package abx_pkg;
   localparam int XLEN = 32;
   localparam int RIDX_W = 5;
   localparam int NREGS = 32;
   // instruction field positions
   localparam int FLD_A_LSB = 27;
   localparam int FLD_B_LSB = 22;
   localparam int FLD_C_LSB = 17;
   localparam int FLD_EXT_LSB = 6;
   localparam int FLD_IMM_LSB = 6;
   localparam int EXT_W = 11;
   localparam int EXT_CODE_LSB = 5;
   // major opcodes
   localparam logic [5:0] OP_RTYPE = 6'h3a;
   localparam logic [5:0] OP_ADD_IMM = 6'h04;
   localparam logic [5:0] OP_AND_HI = 6'h2c;
   localparam logic [5:0] OP_AND_LO = 6'h0c;
   localparam logic [5:0] OP_BR_EQ = 6'h26;
   // extension codes (bits 16..11 of the word)
   localparam logic [5:0] OPXC_ADD = 6'h31;
   localparam logic [5:0] OPXC_AND = 6'h0e;
   localparam logic [15:0] HALF_ZERO = 16'h0000;
   localparam logic [31:0] PC_STEP = 32'h0000_0004;
   localparam logic [31:0] PC_RESET = 32'h0000_0000;
   localparam logic [31:0] REG_RESET = 32'h0000_0000;

   // decoded operation kinds
   typedef enum logic [2:0] {
      ABX_NONE = 3'h0,
      ABX_ADD  = 3'h1,
      ABX_ADDI = 3'h3,
      ABX_AND  = 3'h2,
      ABX_ANDH = 3'h6,
      ABX_ANDL = 3'h7,
      ABX_BEQ  = 3'h5
   } abx_op_t;

   // register-file write request
   typedef struct packed {
      logic en;
      logic [4:0] idx;
      logic [31:0] data;
   } abx_wr_t;
endpackage

// file: abx_regfile.sv
// abx_regfile: 32 x 32 general register file, two read ports, one write port
// assumes: synchronous active-low reset, writes from the execute top only
`timescale 1ns/1ps
`default_nettype none
module abx_regfile (
   input wire logic clk, // processor clock
   input wire logic rst_n, // synchronous reset, active low
   input wire logic [4:0] rd_a_idx, // first read index
   input wire logic [4:0] rd_b_idx, // second read index
   output logic [31:0] rd_a_data, // first read data
   output logic [31:0] rd_b_data, // second read data
   input wire abx_pkg::abx_wr_t wr // write request
);
   logic [31:0] regs_ff [abx_pkg::NREGS];

   // one write per cycle, all entries cleared at reset
   genvar gi;
   generate
      for (gi = 0; gi < abx_pkg::NREGS; gi++) begin : g_reg
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               regs_ff[gi] <= abx_pkg::REG_RESET;
            end else if (wr.en && wr.idx == 5'(gi)) begin
               regs_ff[gi] <= wr.data;
            end
         end
      end
   endgenerate

   // combinational read ports
   assign rd_a_data = regs_ff[rd_a_idx];
   assign rd_b_data = regs_ff[rd_b_idx];
endmodule
`default_nettype wire

// file: abx_exec.sv
// abx_exec: execute slice for add, addi, and, andhi, andi and beq
// assumes: one instruction issued per valid strobe from fetch on the same clock
`timescale 1ns/1ps
`default_nettype none
module abx_exec (
   input wire logic clk, // processor clock, 40 MHz
   input wire logic rst_n, // synchronous reset, active low
   input wire logic issue_valid, // instruction word valid this cycle
   input wire logic [31:0] issue_word, // instruction word
   output logic [31:0] pc, // current program counter
   output logic done, // pulse: instruction retired
   output logic reserved_op, // pulse: reserved encoding seen
   output logic [31:0] result, // last written result
   output logic [4:0] result_idx, // last written register index
   output logic result_we // pulse: register written
);
   logic [31:0] pc_ff;
   logic done_ff;
   logic rsv_ff;
   logic [31:0] res_ff;
   logic [4:0] res_idx_ff;
   logic res_we_ff;
   logic [4:0] first_source_register;
   logic [4:0] second_operand_register;
   logic [4:0] destination_register;
   logic [5:0] opcode;
   logic [10:0] opcode_extension;
   logic [15:0] sixteen_bit_immediate;
   logic [31:0] imm_sext;
   logic [31:0] val_a;
   logic [31:0] val_b;
   abx_pkg::abx_op_t op_kind;
   abx_pkg::abx_wr_t nxt_wr;
   logic [31:0] nxt_pc;
   logic [31:0] pc_seq;

   // field split of the instruction word
   assign first_source_register = issue_word[abx_pkg::FLD_A_LSB +: 5];
   assign second_operand_register = issue_word[abx_pkg::FLD_B_LSB +: 5];
   assign destination_register = issue_word[abx_pkg::FLD_C_LSB +: 5];
   assign opcode = issue_word[5:0];
   assign opcode_extension = issue_word[abx_pkg::FLD_EXT_LSB +: abx_pkg::EXT_W];
   assign sixteen_bit_immediate = issue_word[abx_pkg::FLD_IMM_LSB +: 16];
   assign imm_sext = {{16{sixteen_bit_immediate[15]}}, sixteen_bit_immediate};

   abx_regfile u_rf (
      .clk(clk),
      .rst_n(rst_n),
      .rd_a_idx(first_source_register),
      .rd_b_idx(second_operand_register),
      .rd_a_data(val_a),
      .rd_b_data(val_b),
      .wr(nxt_wr)
   );

   // decode: major opcode, then extension for the register class
   always_comb begin
      op_kind = abx_pkg::ABX_NONE;
      unique case (opcode)
         abx_pkg::OP_RTYPE: begin
            if (opcode_extension[abx_pkg::EXT_CODE_LSB +: 6] == abx_pkg::OPXC_ADD) begin
               op_kind = abx_pkg::ABX_ADD;
            end else if (opcode_extension[abx_pkg::EXT_CODE_LSB +: 6] == abx_pkg::OPXC_AND) begin
               op_kind = abx_pkg::ABX_AND;
            end
         end
         abx_pkg::OP_ADD_IMM: op_kind = abx_pkg::ABX_ADDI;
         abx_pkg::OP_AND_HI: op_kind = abx_pkg::ABX_ANDH;
         abx_pkg::OP_AND_LO: op_kind = abx_pkg::ABX_ANDL;
         abx_pkg::OP_BR_EQ: op_kind = abx_pkg::ABX_BEQ;
         default: op_kind = abx_pkg::ABX_NONE; // reserved here
      endcase
   end

   // result and destination selection; at most one write per issued instruction
   always_comb begin
      nxt_wr = '0;
      if (issue_valid) begin
         unique case (op_kind)
            abx_pkg::ABX_ADD: begin
               nxt_wr = '{1'b1, destination_register, val_a + val_b};
            end
            abx_pkg::ABX_ADDI: begin
               nxt_wr = '{1'b1, second_operand_register, val_a + imm_sext};
            end
            abx_pkg::ABX_AND: begin
               nxt_wr = '{1'b1, destination_register, val_a & val_b};
            end
            abx_pkg::ABX_ANDH: begin
               nxt_wr = '{1'b1, second_operand_register,
                          val_a & {sixteen_bit_immediate, abx_pkg::HALF_ZERO}};
            end
            abx_pkg::ABX_ANDL: begin
               nxt_wr = '{1'b1, second_operand_register,
                          val_a & {abx_pkg::HALF_ZERO, sixteen_bit_immediate}};
            end
            default: nxt_wr = '0; // branch and reserved codes write nothing
         endcase
      end
   end

   // next pc: sequential step or taken branch; offset alignment is trusted
   assign pc_seq = pc_ff + abx_pkg::PC_STEP;
   always_comb begin
      nxt_pc = pc_ff;
      if (issue_valid) begin
         nxt_pc = pc_seq;
         if (op_kind == abx_pkg::ABX_BEQ && val_a == val_b) begin
            nxt_pc = pc_seq + imm_sext;
         end
      end
   end

   // program counter
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pc_ff <= abx_pkg::PC_RESET;
      end else begin
         pc_ff <= nxt_pc;
      end
   end

   // retire and reserved-code pulses
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         done_ff <= 1'b0;
         rsv_ff <= 1'b0;
      end else begin
         done_ff <= issue_valid;
         rsv_ff <= issue_valid && op_kind == abx_pkg::ABX_NONE;
      end
   end

   // last write echo
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         res_ff <= abx_pkg::REG_RESET;
         res_idx_ff <= 5'h00;
         res_we_ff <= 1'b0;
      end else begin
         res_we_ff <= nxt_wr.en;
         if (nxt_wr.en) begin
            res_ff <= nxt_wr.data;
            res_idx_ff <= nxt_wr.idx;
         end
      end
   end

   assign pc = pc_ff;
   assign done = done_ff;
   assign reserved_op = rsv_ff;
   assign result = res_ff;
   assign result_idx = res_idx_ff;
   assign result_we = res_we_ff;

   // data results, visible one cycle after the issuing edge
   chk_add_result: assert property (@(posedge clk) disable iff (!rst_n)
      issue_valid && op_kind == abx_pkg::ABX_ADD |=> result_we
      && result == $past(val_a) + $past(val_b)
      && result_idx == $past(destination_register))
      else $error("add result wrong");
   chk_addi_result: assert property (@(posedge clk) disable iff (!rst_n)
      issue_valid && op_kind == abx_pkg::ABX_ADDI |=> result_we
      && result == $past(val_a) + $past(imm_sext)
      && result_idx == $past(second_operand_register))
      else $error("addi result wrong");
   chk_and_result: assert property (@(posedge clk) disable iff (!rst_n)
      issue_valid && op_kind == abx_pkg::ABX_AND
      |=> result == ($past(val_a) & $past(val_b))
      && result_idx == $past(destination_register))
      else $error("and result wrong");
   chk_andhi_low: assert property (@(posedge clk) disable iff (!rst_n)
      issue_valid && op_kind == abx_pkg::ABX_ANDH |=> result[15:0] == 16'h0000
      && result[31:16] == ($past(val_a[31:16]) & $past(sixteen_bit_immediate))
      && result_idx == $past(second_operand_register))
      else $error("andhi result wrong");
   chk_andi_high: assert property (@(posedge clk) disable iff (!rst_n)
      issue_valid && op_kind == abx_pkg::ABX_ANDL |=> result[31:16] == 16'h0000
      && result[15:0] == ($past(val_a[15:0]) & $past(sixteen_bit_immediate))
      && result_idx == $past(second_operand_register))
      else $error("andi result wrong");

   // branch target, plain step, and a single update per instruction
   chk_beq_target: assert property (@(posedge clk) disable iff (!rst_n)
      issue_valid && op_kind == abx_pkg::ABX_BEQ |=> pc == (($past(val_a) == $past(val_b))
      ? $past(pc) + 32'h4 + $past(imm_sext) : $past(pc) + 32'h4))
      else $error("branch target wrong");
   chk_pc_step: assert property (@(posedge clk) disable iff (!rst_n)
      issue_valid && op_kind != abx_pkg::ABX_BEQ
      |=> pc == $past(pc) + abx_pkg::PC_STEP)
      else $error("pc did not step by one word");
   chk_beq_nowrite: assert property (@(posedge clk) disable iff (!rst_n)
      issue_valid && op_kind == abx_pkg::ABX_BEQ |=> !result_we)
      else $error("branch wrote a register");
   chk_done_pulse: assert property (@(posedge clk) disable iff (!rst_n)
      issue_valid |=> done)
      else $error("issued instruction not retired");
   chk_idle_hold: assert property (@(posedge clk) disable iff (!rst_n)
      !issue_valid |=> $stable(pc) && !result_we && !done)
      else $error("state changed while idle");

   // reserved encodings retire with no register write
   chk_reserved_flag: assert property (@(posedge clk) disable iff (!rst_n)
      issue_valid && opcode == abx_pkg::OP_RTYPE
      && opcode_extension[abx_pkg::EXT_CODE_LSB +: 6] != abx_pkg::OPXC_ADD
      && opcode_extension[abx_pkg::EXT_CODE_LSB +: 6] != abx_pkg::OPXC_AND
      |=> reserved_op && !result_we)
      else $error("reserved code not flagged");
   chk_reserved_major: assert property (@(posedge clk) disable iff (!rst_n)
      issue_valid && opcode != abx_pkg::OP_RTYPE && opcode != abx_pkg::OP_ADD_IMM
      && opcode != abx_pkg::OP_AND_HI && opcode != abx_pkg::OP_AND_LO
      && opcode != abx_pkg::OP_BR_EQ
      |=> reserved_op && !result_we && pc == $past(pc) + abx_pkg::PC_STEP)
      else $error("reserved opcode not flagged");
endmodule
`default_nettype wire

// file: abx_exec_tb.sv
// abx_exec_tb: self-checking bench for the add/and/beq execute slice
// assumes: abx_pkg and the design files are compiled first; one 40 MHz clock
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
   $display("wrong value %s expected %h seen %h", nm, e, g); end end
module abx_exec_tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic issue_valid = 1'b0;
   logic [31:0] issue_word = 32'h0000_0000;
   logic [31:0] pc;
   logic done;
   logic reserved_op;
   logic [31:0] result;
   logic [4:0] result_idx;
   logic result_we;
   int fail_count = 0;
   int n_tests = 0;
   logic [31:0] pc_e = 32'h0000_0000; // expected program counter

   abx_exec dut (.clk(clk), .rst_n(rst_n), .issue_valid(issue_valid),
      .issue_word(issue_word), .pc(pc), .done(done), .reserved_op(reserved_op),
      .result(result), .result_idx(result_idx), .result_we(result_we));

   // 25 ns clock
   always #12.5 clk = ~clk;

   // word builders for register and immediate formats
   function automatic logic [31:0] rw(logic [4:0] a, logic [4:0] b, logic [4:0] c,
         logic [5:0] x);
      return {a, b, c, x, 5'h00, abx_pkg::OP_RTYPE};
   endfunction
   function automatic logic [31:0] iw(logic [4:0] a, logic [4:0] b, logic [15:0] imm,
         logic [5:0] op);
      return {a, b, imm, op};
   endfunction

   // one instruction per cycle; leaves valid high so calls run back to back
   task automatic issue(input logic [31:0] w);
      issue_valid = 1'b1;
      issue_word = w;
      pc_e = pc_e + abx_pkg::PC_STEP;
      @(posedge clk);
      #1;
   endtask

   // common checks on the cycle after an issue
   task automatic chk_out(input logic we_e, input logic [4:0] idx_e, input logic rsv_e);
      `CHK("result_we", we_e, result_we)
      `CHK("done", 1'b1, done)
      `CHK("pc", pc_e, pc)
      `CHK("reserved_op", rsv_e, reserved_op)
      if (we_e) `CHK("result_idx", idx_e, result_idx)
   endtask

   // a quiet cycle must retire nothing and hold the pc
   task automatic idle();
      issue_valid = 1'b0;
      @(posedge clk);
      #1;
      `CHK("done idle", 1'b0, done)
      `CHK("we idle", 1'b0, result_we)
      `CHK("pc idle", pc_e, pc)
   endtask

   // every output at its reset value
   task automatic chk_rst();
      `CHK("pc reset", abx_pkg::PC_RESET, pc)
      `CHK("result reset", abx_pkg::REG_RESET, result)
      `CHK("done reset", 1'b0, done)
      `CHK("we reset", 1'b0, result_we)
      `CHK("idx reset", 5'h00, result_idx)
      `CHK("reserved reset", 1'b0, reserved_op)
   endtask

   // immediate add with negative and positive immediates, back to back
   task automatic t_addi();
      issue(iw(5'h00, 5'h01, 16'hfff0, abx_pkg::OP_ADD_IMM));
      chk_out(1'b1, 5'h01, 1'b0);
      `CHK("addi neg", 32'hffff_fff0, result)
      issue(iw(5'h00, 5'h02, 16'h7ffc, abx_pkg::OP_ADD_IMM));
      chk_out(1'b1, 5'h02, 1'b0);
      `CHK("addi pos", 32'h0000_7ffc, result)
      idle();
   endtask

   // register add wraps with no carry; register and
   task automatic t_add_and();
      issue(rw(5'h01, 5'h02, 5'h03, abx_pkg::OPXC_ADD));
      chk_out(1'b1, 5'h03, 1'b0);
      `CHK("add", 32'h0000_7fec, result)
      issue(rw(5'h01, 5'h02, 5'h04, abx_pkg::OPXC_AND));
      chk_out(1'b1, 5'h04, 1'b0);
      `CHK("and", 32'h0000_7ff0, result)
   endtask

   // and with immediate in the high and in the low halfword
   task automatic t_and_imm();
      issue(iw(5'h01, 5'h05, 16'ha5a5, abx_pkg::OP_AND_HI));
      chk_out(1'b1, 5'h05, 1'b0);
      `CHK("andhi", 32'ha5a5_0000, result)
      issue(iw(5'h01, 5'h06, 16'ha5a5, abx_pkg::OP_AND_LO));
      chk_out(1'b1, 5'h06, 1'b0);
      `CHK("andi", 32'h0000_a5a0, result)
   endtask

   // branch taken backwards, then not taken; no register write
   task automatic t_beq();
      issue(iw(5'h01, 5'h01, 16'hfff8, abx_pkg::OP_BR_EQ));
      pc_e = pc_e - 32'h0000_0008;
      chk_out(1'b0, 5'h00, 1'b0);
      issue(iw(5'h01, 5'h02, 16'h0010, abx_pkg::OP_BR_EQ));
      chk_out(1'b0, 5'h00, 1'b0);
      `CHK("result after beq", 32'h0000_a5a0, result)
   endtask

   // reserved extension and opcode: flag, pc advances, nothing written
   task automatic t_reserved();
      issue(rw(5'h01, 5'h02, 5'h07, 6'h3f));
      chk_out(1'b0, 5'h00, 1'b1);
      issue(iw(5'h01, 5'h07, 16'h0000, 6'h3f));
      chk_out(1'b0, 5'h00, 1'b1);
      `CHK("result after reserved", 32'h0000_a5a0, result)
      issue(rw(5'h07, 5'h00, 5'h08, abx_pkg::OPXC_ADD));
      chk_out(1'b1, 5'h08, 1'b0);
      `CHK("untouched reg", 32'h0000_0000, result)
      idle();
   endtask

   // mid-run reset clears pc and outputs; only registers 1 and 2 are checked, through one add
   task automatic t_reset();
      rst_n = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk_rst();
      rst_n = 1'b1;
      pc_e = abx_pkg::PC_RESET;
      issue(rw(5'h01, 5'h02, 5'h03, abx_pkg::OPXC_ADD));
      chk_out(1'b1, 5'h03, 1'b0);
      `CHK("cleared regs", abx_pkg::REG_RESET, result)
      idle();
   endtask

   // counts line, verdict, end of run
   task automatic print_verdict();
      $display("mismatches %0d, checks %0d", fail_count, n_tests);
      if (fail_count == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // a hang counts as a mismatch
   initial begin
      #100000;
      fail_count++;
      print_verdict();
   end

   // reset for two edges, then the scenarios
   initial begin
      repeat (2) @(posedge clk);
      #1;
      chk_rst();
      rst_n = 1'b1;
      t_addi();
      t_add_and();
      t_and_imm();
      t_beq();
      t_reserved();
      t_reset();
      print_verdict();
   end
endmodule
`default_nettype wire
